/* File: design/usc_defs.svh */
/*
  constants of the setup capture and dma pacing block: register indices,
  control field positions, reset values and timing counts.
  assumes a 25 mhz core clock and apb byte addresses of four times the index.
*/
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

// register indices, byte address is four times the index
`define USC_IDX_REQ_TYPE    14'h1a00
`define USC_IDX_REQ_CODE    14'h1a01
`define USC_IDX_VALUE_LOW   14'h1a02
`define USC_IDX_VALUE_HIGH  14'h1a03
`define USC_IDX_INDEX_LOW   14'h1a04
`define USC_IDX_INDEX_HIGH  14'h1a05
`define USC_IDX_LENGTH_LOW  14'h1a06
`define USC_IDX_LENGTH_HIGH 14'h1a07
`define USC_IDX_CH0_CTRL    14'h1a08
`define USC_IDX_CH1_CTRL    14'h1a09
`define USC_IDX_CH0_GAP     14'h1a11

// dma control fields
`define USC_CTRL_EN_BIT      0
`define USC_CTRL_SINGLE_BIT  2
`define USC_CTRL_EP_LSB      4
`define USC_CTRL_EP_MSB      6
`define USC_CTRL_SUSPEND_BIT 7

// reset values
`define USC_CTRL_RST  8'h00
`define USC_GAP_RST   8'h00
`define USC_SETUP_RST 8'h00

// timing
`define USC_CLK_PERIOD_NS 40
`define USC_GAP_UNIT_NS   84
`define USC_GAP_UNIT_CYC  ((`USC_GAP_UNIT_NS + `USC_CLK_PERIOD_NS - 1) / `USC_CLK_PERIOD_NS)
`define USC_REQ_EN_CYC    1

`endif

/* File: design/usc_pkg.sv */
/*
  types of the setup capture and dma pacing block.
  assumes usc_defs.svh for all numeric constants.
*/
package usc_pkg;
  typedef logic [7:0]  usc_byte_t;
  typedef logic [15:0] usc_word_t;
  typedef logic [9:0]  usc_gap_t;
  typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_GAP} usc_dma_state_e;
endpackage

/* File: design/usc_stream_if.sv */
/*
  valid/ready word stream between the pacing logic and its buffer.
  assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface usc_stream_if;
  import usc_pkg::*;
  logic      valid;
  logic      ready;
  usc_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: design/usc_word_buffer.sv */
/*
  two-entry word buffer with valid and ready on both sides.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module usc_word_buffer
  import usc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // fill and drain sides
  usc_stream_if.snk fill,
  usc_stream_if.src drain
);
  usc_word_t  mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // full and empty straight from the count, no bypass path
  assign fill.ready  = (count != 2'h2);
  assign drain.valid = (count != 2'h0);
  assign drain.data  = mem[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // storage
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr] <= fill.data;
  end

  // pointers and occupancy
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: design/usc_setup_dma.sv */
/*
  setup packet capture and dma request pacing of a usb device controller, with an apb slave.
  assumes setup bytes arrive from link logic on core_clk, the dma
  acknowledge pins are asynchronous, and usb_bus_reset is a core_clk level.
*/
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "usc_defs.svh"

// Overview of operation
// - capture eight setup bytes without cpu help
// - second byte goes to request code
// - third byte goes to value low
// - fourth byte goes to value high
// - fifth byte goes to index low
// - sixth byte goes to index high
// - seventh byte goes to length low
// - eighth byte goes to length high
// - value index length clear on both resets
// - same endpoint makes both channels equivalent
// - suspend bit set stops further requests
// - suspend cleared resumes with the held word
// - single mode waits enable plus n units
// - gap register cleared by hardware reset only
module usc_setup_dma
  import usc_pkg::*;
(
  // clock and resets
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        usb_bus_reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // setup byte stream from the link
  input  wire logic        setup_start,
  input  wire logic        setup_byte_valid,
  input  wire logic [7:0]  setup_byte,
  output logic             setup_byte_ready,
  output logic             setup_complete,
  // endpoint words towards dma
  input  wire logic        ep_word_valid,
  input  wire logic [15:0] ep_word,
  output logic             ep_word_ready,
  // dma partner pins
  output logic [1:0]       dma_request_out,
  input  wire logic [1:0]  dma_acknowledge_in,
  output logic [15:0]      dma_data_out
);
  usc_byte_t      setup_q [0:7];
  logic [63:0]    setup_flat;
  logic [2:0]     idx;
  logic           capturing;
  logic           take;
  usc_byte_t      dma_ch0_control;
  usc_byte_t      dma_ch1_control;
  usc_byte_t      dma_ch0_request_gap;
  logic [13:0]    reg_idx;
  logic           wr_acc;
  logic [1:0]     ack_meta;
  logic [1:0]     ack_sync;
  logic [1:0]     ack_prev;
  logic [1:0]     ack_rise;
  logic           same_ep;
  logic           ack_done;
  usc_dma_state_e state;
  usc_gap_t       gap_cnt;
  usc_gap_t       gap_load;
  logic           req0;
  logic           suspend;
  usc_stream_if   in_s ();
  usc_stream_if   out_s ();

  // the link is never stalled; bytes after the eighth are dropped
  assign setup_byte_ready = 1'b1;
  assign take             = setup_byte_valid && capturing;

  // byte position within the setup stage
  always_ff @(posedge core_clk)
  begin
    if (rst || usb_bus_reset)
    begin
      idx       <= 3'h0;
      capturing <= 1'b0;
    end
    else if (setup_start)
    begin
      idx       <= 3'h0;
      capturing <= 1'b1;
    end
    else if (take)
    begin
      idx <= idx + 3'h1;
      if (idx == 3'h7)
        capturing <= 1'b0;
    end
  end

  // one pulse once the eighth byte is stored
  always_ff @(posedge core_clk)
  begin
    if (rst)
      setup_complete <= 1'b0;
    else
      setup_complete <= take && (idx == 3'h7);
  end

  // one byte register per setup position; type and code carry no reset
  generate
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_setup
      assign setup_flat[8*gi +: 8] = setup_q[gi];
      if (gi < 2)
      begin : g_noreset
        always_ff @(posedge core_clk)
        begin
          if (take && (idx == 3'(gi)))
            setup_q[gi] <= setup_byte;
        end
      end
      else
      begin : g_reset
        always_ff @(posedge core_clk)
        begin
          if (rst || usb_bus_reset)
            setup_q[gi] <= `USC_SETUP_RST;
          else if (take && (idx == 3'(gi)))
            setup_q[gi] <= setup_byte;
        end
      end
    end
  endgenerate

  // apb decode; zero wait states, data latched in the setup phase
  assign pready  = 1'b1;
  assign reg_idx = paddr[15:2];
  assign wr_acc  = psel && penable && pwrite && !pslverr;

  // read data and error, registered so outputs come from flops
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      if (paddr[1:0] != 2'h0)
        pslverr <= 1'b1;
      else if (reg_idx >= `USC_IDX_REQ_TYPE && reg_idx <= `USC_IDX_LENGTH_HIGH)
      begin
        prdata  <= {24'h0, setup_q[reg_idx[2:0]]};
        pslverr <= pwrite; // setup bytes are read only
      end
      else if (reg_idx == `USC_IDX_CH0_CTRL)
        prdata <= {24'h0, dma_ch0_control};
      else if (reg_idx == `USC_IDX_CH1_CTRL)
        prdata <= {24'h0, dma_ch1_control};
      else if (reg_idx == `USC_IDX_CH0_GAP)
        prdata <= {24'h0, dma_ch0_request_gap};
      else
        pslverr <= 1'b1;
    end
  end

  // dma control: kept across bus reset, bits 1 and 3 stored as written
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dma_ch0_control <= `USC_CTRL_RST;
      dma_ch1_control <= `USC_CTRL_RST;
    end
    else if (wr_acc && reg_idx == `USC_IDX_CH0_CTRL)
      dma_ch0_control <= pwdata[7:0];
    else if (wr_acc && reg_idx == `USC_IDX_CH1_CTRL)
      dma_ch1_control <= pwdata[7:0];
  end

  // interval register ignores the usb bus reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      dma_ch0_request_gap <= `USC_GAP_RST;
    else if (wr_acc && reg_idx == `USC_IDX_CH0_GAP)
      dma_ch0_request_gap <= pwdata[7:0];
  end

  // acknowledge pins: three flops each, edge taken from the second stage
  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_ack
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          ack_meta[gi] <= 1'b0;
          ack_sync[gi] <= 1'b0;
          ack_prev[gi] <= 1'b0;
        end
        else
        begin
          ack_meta[gi] <= dma_acknowledge_in[gi];
          ack_sync[gi] <= ack_meta[gi];
          ack_prev[gi] <= ack_sync[gi];
        end
      end
      assign ack_rise[gi] = ack_sync[gi] && !ack_prev[gi];
    end
  endgenerate

  // channels on one endpoint share request and acknowledge
  assign same_ep = dma_ch0_control[`USC_CTRL_EN_BIT] && dma_ch1_control[`USC_CTRL_EN_BIT]
                && (dma_ch0_control[`USC_CTRL_EP_MSB:`USC_CTRL_EP_LSB]
                 == dma_ch1_control[`USC_CTRL_EP_MSB:`USC_CTRL_EP_LSB]);
  assign ack_done = (state == DMA_REQ) && (ack_rise[0] || (same_ep && ack_rise[1]));
  assign dma_request_out = {same_ep && req0, req0};

  // buffer between endpoint words and the dma pins
  assign in_s.valid    = ep_word_valid;
  assign in_s.data     = ep_word;
  assign ep_word_ready = in_s.ready;
  assign out_s.ready   = ack_done; // a word leaves only when its transfer completes

  usc_word_buffer u_buf (
    .core_clk (core_clk),
    .rst      (rst),
    .fill     (in_s),
    .drain    (out_s)
  );

  // pacing time: request enable plus n interval units, single mode only
  assign suspend  = dma_ch0_control[`USC_CTRL_SUSPEND_BIT];
  assign gap_load = usc_gap_t'(`USC_REQ_EN_CYC)
                  + (dma_ch0_control[`USC_CTRL_SINGLE_BIT]
                     ? usc_gap_t'(dma_ch0_request_gap) * usc_gap_t'(`USC_GAP_UNIT_CYC)
                     : usc_gap_t'(0));

  // request state machine; suspend drops the request, word stays queued
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state        <= DMA_IDLE;
      req0         <= 1'b0;
      gap_cnt      <= '0;
      dma_data_out <= 16'h0;
    end
    else
    begin
      case (state)
        DMA_IDLE:
        begin
          if (out_s.valid && !suspend && dma_ch0_control[`USC_CTRL_EN_BIT])
          begin
            state        <= DMA_REQ;
            req0         <= 1'b1;
            dma_data_out <= out_s.data;
          end
        end
        DMA_REQ:
        begin
          if (ack_done)
          begin
            state   <= DMA_GAP;
            req0    <= 1'b0;
            gap_cnt <= gap_load;
          end
          else if (suspend)
          begin
            state <= DMA_IDLE;
            req0  <= 1'b0;
          end
        end
        DMA_GAP:
        begin
          if (gap_cnt <= usc_gap_t'(1))
            state <= DMA_IDLE;
          gap_cnt <= gap_cnt - usc_gap_t'(1);
        end
        default:
        begin
          state <= DMA_IDLE;
          req0  <= 1'b0;
        end
      endcase
    end
  end

  // helpers for the checks below
  logic [2:0]  last_idx;
  usc_byte_t   last_byte;
  logic        take_d;
  usc_gap_t    since_done;
  usc_gap_t    last_gap;
  logic        done_seen;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      take_d     <= 1'b0;
      last_idx   <= 3'h0;
      last_byte  <= 8'h0;
      since_done <= '0;
      last_gap   <= '0;
      done_seen  <= 1'b0;
    end
    else
    begin
      take_d    <= take && !usb_bus_reset;
      last_idx  <= idx;
      last_byte <= setup_byte;
      if (ack_done)
      begin
        since_done <= '0;
        last_gap   <= gap_load;
        done_seen  <= 1'b1;
      end
      else if (since_done != 10'h3ff)
        since_done <= since_done + usc_gap_t'(1);
    end
  end

  a_setup_done_pulse: assert property (@(posedge core_clk) disable iff (rst)
    take && idx == 3'h7 |=> setup_complete ##1 !setup_complete)
    else $error("setup complete not pulsed after eighth byte");
  a_code_capture: assert property (@(posedge core_clk) disable iff (rst)
    take && idx == 3'h1 |=> setup_q[1] == $past(setup_byte))
    else $error("request code byte not captured");
  a_byte_placed: assert property (@(posedge core_clk)
    disable iff (rst)
    take_d |-> setup_q[last_idx] == last_byte)
    else $error("setup byte stored at wrong position");
  a_bus_reset_clear: assert property (@(posedge core_clk) disable iff (rst)
    usb_bus_reset |=> setup_flat[63:16] == 48'h0)
    else $error("setup fields not cleared by bus reset");
  // second pin acknowledge must end a shared request just like the first
  a_same_ep_mirror: assert property (@(posedge core_clk) disable iff (rst)
    same_ep && state == DMA_REQ && ack_rise[1] |=> dma_request_out == 2'b00)
    else $error("shared endpoint acknowledge on second pin ignored");
  a_suspend_no_req: assert property (@(posedge core_clk) disable iff (rst)
    suspend && !ack_done ##1 suspend |-> !dma_request_out[0])
    else $error("request while suspended");
  a_suspend_keeps: assert property (@(posedge core_clk) disable iff (rst)
    out_s.valid && !ack_done |=> out_s.valid && $stable(out_s.data))
    else $error("word lost without completed transfer");
  a_gap_length: assert property (@(posedge core_clk) disable iff (rst)
    $rose(req0) && done_seen |-> since_done >= last_gap)
    else $error("request reasserted before interval elapsed");
  a_gap_bus_keep: assert property (@(posedge core_clk) disable iff (rst)
    usb_bus_reset && !wr_acc |=> $stable(dma_ch0_request_gap))
    else $error("interval register changed by bus reset");
  a_setup_hold: assert property (@(posedge core_clk) disable iff (rst)
    !take && !usb_bus_reset |=> $stable(setup_flat))
    else $error("setup bytes changed without capture");
endmodule

/* File: tb/usc_dma_partner.sv */
/*
  far side dma acknowledger model: answers each request with an acknowledge level.
  assumes requests are core_clk levels and the bench picks delay and pin.
*/
`timescale 1ns/1ps
module usc_dma_partner
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // bench control: wait before answering, pin used
  input  wire logic [7:0] delay,
  input  wire logic       sel,
  // dma pins
  input  wire logic [1:0] req,
  output logic [1:0]      ack
);
  int cnt;

  // ack after delay cycles, dropped once request drops so each ack is a new edge
  always @(posedge core_clk)
  begin
    if (rst || req[sel] !== 1'b1)
    begin
      cnt <= 0;
      ack <= 2'b00;
    end
    else if (cnt < delay)
      cnt <= cnt + 1;
    else
      ack[sel] <= 1'b1;
  end
endmodule

/* File: tb/tb.sv */
/*
  self-checking bench of the setup capture and dma pacing block.
  assumes usc_dma_partner answers requests and apb offsets are four times the index.
*/
`timescale 1ns/1ps
`include "usc_defs.svh"
module tb;
  import usc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        usb_bus_reset = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        setup_start = 1'b0;
  logic        setup_byte_valid = 1'b0;
  logic [7:0]  setup_byte = '0;
  logic        ep_word_valid = 1'b0;
  logic [15:0] ep_word = '0;
  logic [7:0]  ack_delay = '0;
  logic        ack_sel = 1'b0;
  logic        pready, pslverr, setup_byte_ready, setup_complete, ep_word_ready, err;
  logic [31:0] prdata, rd;
  logic [1:0]  dma_request_out, dma_acknowledge_in;
  logic [15:0] dma_data_out;
  logic        susp = 1'b0;
  logic        same_ep = 1'b0;
  logic        req_q = 1'b0;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          low_n = -1;
  int          gap_exp, j, k;
  int          m_setup [8];
  int          tx_q [$];
  int          exp_q [$];

  always #20 core_clk = ~core_clk;

  usc_setup_dma dut (.core_clk(core_clk), .rst(rst), .usb_bus_reset(usb_bus_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .setup_start(setup_start),
    .setup_byte_valid(setup_byte_valid), .setup_byte(setup_byte),
    .setup_byte_ready(setup_byte_ready), .setup_complete(setup_complete),
    .ep_word_valid(ep_word_valid), .ep_word(ep_word), .ep_word_ready(ep_word_ready),
    .dma_request_out(dma_request_out), .dma_acknowledge_in(dma_acknowledge_in),
    .dma_data_out(dma_data_out));

  usc_dma_partner partner (.core_clk(core_clk), .rst(rst), .delay(ack_delay), .sel(ack_sel),
    .req(dma_request_out), .ack(dma_acknowledge_in));

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // no fixed wait count: only the cycle ceiling ends a stuck transfer
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [13:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, e);
  endtask

  task hw_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    low_n = -1;
  endtask

  // start pulse then eight random bytes back to back
  task setup_pkt;
    int i, hi;
    @(posedge core_clk);
    setup_start <= 1'b1;
    @(posedge core_clk);
    setup_start <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      m_setup[i] = $urandom() % 256;
      setup_byte_valid <= 1'b1;
      setup_byte <= m_setup[i][7:0];
      @(posedge core_clk);
    end
    setup_byte_valid <= 1'b0;
    hi = 0;
    repeat (3)
    begin
      @(posedge core_clk);
      hi += setup_complete;
    end
    chk(hi, 1);
    chk(setup_byte_ready, 1'b1);
  endtask

  // channel setup at init only, then four random words queued
  task dma_cfg(input logic sgl, input logic [7:0] n, input logic same);
    int w;
    hw_reset();
    same_ep = same;
    ack_sel <= same;
    gap_exp = `USC_REQ_EN_CYC + 1 + (sgl ? n * `USC_GAP_UNIT_CYC : 0);
    apb(1'b1, `USC_IDX_CH0_GAP, n);
    apb(1'b1, `USC_IDX_CH0_CTRL, {4'h1, 1'b0, sgl, 2'b01});
    apb(1'b1, `USC_IDX_CH1_CTRL, {1'b0, same ? 3'h1 : 3'h2, 1'b0, sgl, 2'b01});
    repeat (4)
    begin
      w = $urandom() % 65536;
      tx_q.push_back(w);
      exp_q.push_back(w);
    end
  endtask

  task drain;
    int i;
    i = 0;
    while (exp_q.size() != 0 && i < 3000)
    begin
      @(posedge core_clk);
      i++;
    end
    chk(exp_q.size(), 0);
  endtask

  // feeds queued words into the buffer, head held until accepted
  always @(posedge core_clk)
  begin
    if (ep_word_valid && ep_word_ready)
      void'(tx_q.pop_front());
    ep_word_valid <= (tx_q.size() != 0);
    ep_word <= (tx_q.size() != 0) ? tx_q[0][15:0] : 16'h0;
  end

  // request watcher: word, mirror pin and low time between requests
  always @(posedge core_clk)
  begin
    if (dma_request_out[0] === 1'b1 && req_q === 1'b0)
    begin
      chk(dma_data_out, exp_q[0]);
      chk(dma_request_out[1], same_ep);
      if (low_n >= 0)
        chk(low_n, gap_exp);
      low_n = -1;
    end
    if (dma_request_out[0] === 1'b0 && req_q === 1'b1)
    begin
      low_n = susp ? -1 : 1;
      if (!susp)
        void'(exp_q.pop_front());
    end
    else if (low_n > 0)
      low_n++;
    req_q = dma_request_out[0];
  end

  // cuts a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(13976));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (k = 2; k < 8; k++)
      rdchk(`USC_IDX_REQ_TYPE + 14'(k), 32'h0);
    rdchk(`USC_IDX_CH0_GAP, 32'h0);
    $display("test reset values done");
    setup_pkt();
    setup_pkt();
    for (j = 0; j < 16; j++)
      rdchk(`USC_IDX_REQ_TYPE + 14'(j % 8), m_setup[j % 8]);
    apb(1'b1, `USC_IDX_VALUE_LOW, ~m_setup[2][7:0]);
    chk(err, 1'b1);
    apb(1'b0, 14'h1a10, 8'h00);
    chk(err, 1'b1);
    rdchk(`USC_IDX_VALUE_LOW, m_setup[2]);
    $display("test setup capture done");
    apb(1'b1, `USC_IDX_CH0_GAP, 8'h5a);
    usb_bus_reset <= 1'b1;
    @(posedge core_clk);
    usb_bus_reset <= 1'b0;
    for (k = 2; k < 8; k++)
      rdchk(`USC_IDX_REQ_TYPE + 14'(k), 32'h0);
    rdchk(`USC_IDX_CH0_GAP, 32'h5a);
    hw_reset();
    rdchk(`USC_IDX_CH0_GAP, 32'h0);
    $display("test resets done");
    for (j = 0; j < 3; j++)
    begin
      dma_cfg(j != 0, (j == 1) ? 8'h00 : 8'(1 + $urandom() % 7), j[0]);
      drain();
      $display("test dma mode %0d done", j);
    end
    // suspend while a request waits on a slow acknowledge
    ack_delay <= 8'd40;
    dma_cfg(1'b1, 8'h02, 1'b0);
    k = 0;
    while (dma_request_out[0] !== 1'b1 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    chk(dma_request_out, 2'b01);
    susp = 1'b1;
    apb(1'b1, `USC_IDX_CH0_CTRL, 8'h95);
    repeat (2) @(posedge core_clk);
    repeat (20)
    begin
      @(posedge core_clk);
      chk(dma_request_out, 2'b00);
    end
    ack_delay <= 8'd0;
    apb(1'b1, `USC_IDX_CH0_CTRL, 8'h15);
    susp = 1'b0;
    drain();
    $display("test suspend done");
    complete_run();
  end
endmodule
